// [core/srp_power_seq.sv]
// suspend/resume power sequencer with wake comparator and configuration registers
`timescale 1ns/1ns
module srp_power_seq #(
  parameter int unsigned SEQ_STEP_CYC = srp_pkg::SEQ_STEP_CYC,
  parameter int NUM_PINS = srp_pkg::NUM_PINS
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_WAKE_REQUEST_IN,
  input wire logic I_TOD_TICK,
  input wire logic I_CFG_WE,
  input wire logic I_CFG_RE,
  input wire logic [7:0] I_CFG_ADDR,
  input wire logic [7:0] I_CFG_WDATA,
  input wire logic [NUM_PINS-1:0] I_PPIN_DIR,
  input wire logic [NUM_PINS-1:0] I_PPIN_DATA,
  input wire logic [NUM_PINS-1:0] I_PPIN_PAD,
  output logic O_OSC_POWER_OUT,
  output logic O_TIMING_EN,
  output logic O_EXEC_PERMITTED,
  output logic O_SUPERVISOR_MODE_REQ,
  output logic O_INPUT_LEVEL_SELECT,
  output logic [7:0] O_CFG_RDATA,
  output logic [31:0] O_TOD,
  output logic [NUM_PINS-1:0] O_PPIN_OUT,
  output logic [NUM_PINS-1:0] O_PPIN_OE,
  output logic [NUM_PINS-1:0] O_PPIN_VALUE
);

  localparam int W = srp_pkg::DLY_W;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers and time of day

  logic [31:0] cmp;
  srp_pkg::srp_ctrl_s ctrl;
  logic [7:0] level;
  logic [31:0] tod;
  logic [7:0] rdata;
  logic [31:0] next_cmp;
  srp_pkg::srp_ctrl_s next_ctrl;
  logic [7:0] next_level;
  logic [31:0] next_tod;
  logic [7:0] next_rdata;
  srp_pkg::srp_state_e state;
  srp_pkg::srp_state_e next_state;
  logic dly_done;

  always_comb begin
    next_cmp = cmp;
    next_ctrl = ctrl;
    next_level = level;
    next_rdata = rdata;
    // time keeps running through suspend
    next_tod = I_TOD_TICK ? tod + 32'h0000_0001 : tod;
    if (state == srp_pkg::ST_DOWN && dly_done) begin
      next_ctrl.power_off_cmd = 1'b0;
    end
    if (I_CFG_WE) begin
      // a write in the same cycle overrides the self-clear
      for (int b = 0; b < 4; b++) begin
        if (I_CFG_ADDR == 8'(int'(srp_pkg::OFF_CMP0) + b)) begin
          next_cmp[b*8 +: 8] = I_CFG_WDATA;
        end
      end
      if (I_CFG_ADDR == srp_pkg::OFF_CTRL) begin
        next_ctrl = I_CFG_WDATA;
      end
      if (I_CFG_ADDR == srp_pkg::OFF_LEVEL) begin
        next_level = I_CFG_WDATA;
      end
    end
    if (I_CFG_RE) begin
      next_rdata = 8'h00;
      for (int b = 0; b < 4; b++) begin
        if (I_CFG_ADDR == 8'(int'(srp_pkg::OFF_CMP0) + b)) begin
          next_rdata = cmp[b*8 +: 8];
        end
      end
      if (I_CFG_ADDR == srp_pkg::OFF_CTRL) begin
        next_rdata = ctrl;
      end
      if (I_CFG_ADDR == srp_pkg::OFF_LEVEL) begin
        next_rdata = level;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      cmp <= srp_pkg::CMP_RST;
      ctrl <= srp_pkg::CTRL_RST;
      level <= srp_pkg::LEVEL_RST;
      tod <= srp_pkg::TOD_RST;
      rdata <= 8'h00;
    end else begin
      cmp <= next_cmp;
      ctrl <= next_ctrl;
      level <= next_level;
      tod <= next_tod;
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake pin synchroniser and supervisor request

  logic wake_meta;
  logic wake_sync;
  logic wake_prev;
  logic sup_req;
  logic next_sup_req;

  always_comb begin
    next_sup_req = 1'b0;
    // only a request; powering down stays with software
    if (state == srp_pkg::ST_ACTIVE && wake_sync != wake_prev) begin
      next_sup_req = ctrl.any_change || (wake_sync == ctrl.wake_level);
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
      wake_prev <= 1'b0;
      sup_req <= 1'b0;
    end else begin
      wake_meta <= I_WAKE_REQUEST_IN;
      wake_sync <= wake_meta;
      wake_prev <= wake_sync;
      sup_req <= next_sup_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power control state machine

  logic dly_start;
  logic [W-1:0] dly_cycles;
  logic cmp_match;

  assign cmp_match = (tod == cmp);

  always_comb begin
    next_state = state;
    dly_start = 1'b0;
    dly_cycles = W'(SEQ_STEP_CYC);
    case (state)
      srp_pkg::ST_SUSPEND: begin
        // high level covers both a pulse and a held switch
        if (wake_sync || cmp_match) begin
          next_state = srp_pkg::ST_UP;
          dly_start = 1'b1;
          if (ctrl.quick_resume) begin
            dly_cycles = W'(srp_pkg::QUICK_CYC);
          end
        end
      end
      srp_pkg::ST_UP: begin
        if (dly_done) begin
          next_state = srp_pkg::ST_ACTIVE;
        end
      end
      srp_pkg::ST_ACTIVE: begin
        // comparator match deliberately not looked at here
        if (ctrl.power_off_cmd) begin
          next_state = srp_pkg::ST_DOWN;
          dly_start = 1'b1;
        end
      end
      srp_pkg::ST_DOWN: begin
        if (dly_done) begin
          next_state = srp_pkg::ST_SUSPEND;
        end
      end
      default: begin
        next_state = srp_pkg::ST_SUSPEND;
      end
    endcase
  end

  // reset leaves the chip running, as after a power-on
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      state <= srp_pkg::ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  srp_delay #(.W(W)) u_delay (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_start(dly_start),
    .i_cycles(dly_cycles),
    .o_done(dly_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // programmable pins

  logic [NUM_PINS-1:0] pin_out;
  logic [NUM_PINS-1:0] pin_oe;
  logic [NUM_PINS-1:0] pin_val;

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_val <= '0;
    end else begin
      pin_out <= I_PPIN_DATA;
      pin_oe <= I_PPIN_DIR;
      pin_val <= I_PPIN_PAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: power, timing and execute decoded from the state flops, the rest driven straight from their registers

  assign O_OSC_POWER_OUT = (state != srp_pkg::ST_SUSPEND);
  assign O_TIMING_EN = (state == srp_pkg::ST_ACTIVE);
  assign O_EXEC_PERMITTED = (state == srp_pkg::ST_ACTIVE);
  assign O_SUPERVISOR_MODE_REQ = sup_req;
  assign O_INPUT_LEVEL_SELECT = level[srp_pkg::LEVEL_SEL_BIT];
  assign O_CFG_RDATA = rdata;
  assign O_TOD = tod;
  assign O_PPIN_OUT = pin_out;
  assign O_PPIN_OE = pin_oe;
  assign O_PPIN_VALUE = pin_val;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [W-1:0] up_cnt;

  always_ff @(posedge I_MCLK) begin
    if (I_RST || state != srp_pkg::ST_UP) begin
      up_cnt <= '0;
    end else begin
      up_cnt <= up_cnt + W'(1);
    end
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);

  timing_needs_osc_a: assert property ($fell(O_OSC_POWER_OUT) |->
    !$past(O_TIMING_EN)) else $error("oscillator power dropped while timing ran");
  suspend_quiet_a: assert property (state == srp_pkg::ST_SUSPEND |->
    !O_TIMING_EN && !O_EXEC_PERMITTED) else $error("timing running in suspend");
  tod_advance_a: assert property (I_TOD_TICK |=>
    O_TOD == $past(O_TOD) + 32'h0000_0001) else $error("time count did not advance");
  cmp_wake_a: assert property (state == srp_pkg::ST_SUSPEND && cmp_match |=>
    O_OSC_POWER_OUT) else $error("comparator match did not start power-up");
  pin_wake_a: assert property (state == srp_pkg::ST_SUSPEND && wake_sync |=>
    O_OSC_POWER_OUT) else $error("wake pin did not start power-up");
  cmp_ignore_a: assert property (state == srp_pkg::ST_ACTIVE && !ctrl.power_off_cmd
    |=> O_TIMING_EN) else $error("active mode left without power-off command");
  power_off_cmd_start_a: assert property (state == srp_pkg::ST_ACTIVE && ctrl.power_off_cmd
    |=> !O_TIMING_EN ##0 O_OSC_POWER_OUT) else $error("power-off command did not stop timing");
  up_delay_a: assert property (state == srp_pkg::ST_UP && dly_done |->
    up_cnt == W'(ctrl.quick_resume ? srp_pkg::QUICK_CYC : SEQ_STEP_CYC) - W'(1))
    else $error("power-up step length wrong");
  power_off_cmd_clear_a: assert property (state == srp_pkg::ST_DOWN && dly_done && !I_CFG_WE
    |=> !ctrl.power_off_cmd && !O_OSC_POWER_OUT)
    else $error("power-off command not cleared at suspend");
  level_reset_a: assert property ($past(I_RST) |-> O_INPUT_LEVEL_SELECT)
    else $error("input level not 5V after reset");

  cover_suspend_c: cover property (state == srp_pkg::ST_DOWN ##1 state == srp_pkg::ST_SUSPEND);
  cover_quick_c: cover property (state == srp_pkg::ST_UP && ctrl.quick_resume && dly_done);
  cover_sup_c: cover property (O_SUPERVISOR_MODE_REQ);

endmodule // srp_power_seq

// [core/srp_pkg.sv]
// constants, types and register map of the suspend/resume power sequencer
package srp_pkg;

  // configuration register offsets
  localparam logic [7:0] OFF_CMP0 = 8'h18;
  localparam logic [7:0] OFF_CMP3 = 8'h1B;
  localparam logic [7:0] OFF_CTRL = 8'h1C;
  localparam logic [7:0] OFF_LEVEL = 8'h32;

  // reset values
  localparam logic [31:0] CMP_RST = 32'h0000_0000;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] LEVEL_RST = 8'h01;
  localparam logic [31:0] TOD_RST = 32'h0000_0000;

  // input_level_config field: 1 = 5V thresholds, 0 = 3.3V sensing
  localparam int LEVEL_SEL_BIT = 0;

  localparam int NUM_PINS = 5;

  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SEQ_STEP_MS = 500;
  localparam int unsigned QUICK_US = 100;
  localparam int unsigned SEQ_STEP_CYC = CLK_HZ / 1000 * SEQ_STEP_MS;
  localparam int unsigned QUICK_CYC = CLK_HZ / 1_000_000 * QUICK_US;
  localparam int DLY_W = 23;

  // power_sequence_control layout, bit 7 first
  typedef struct packed {
    logic [3:0] rsv;
    logic any_change;
    logic wake_level;
    logic quick_resume;
    logic power_off_cmd;
  } srp_ctrl_s;

  typedef enum logic [1:0] {
    ST_SUSPEND,
    ST_UP,
    ST_ACTIVE,
    ST_DOWN
  } srp_state_e;

endpackage

// [core/srp_delay.sv]
// one-shot down counter for sequencer step delays
`timescale 1ns/1ns
module srp_delay #(
  parameter int W = srp_pkg::DLY_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [W-1:0] i_cycles,
  output logic o_done
);

  logic [W-1:0] cnt;
  logic busy;
  logic [W-1:0] next_cnt;
  logic next_busy;

  // done marks the last cycle of a load of N, so the caller moves on N cycles after start
  assign o_done = busy && (cnt == W'(1));

  always_comb begin
    next_cnt = cnt;
    next_busy = busy;
    if (i_start) begin
      next_cnt = i_cycles;
      next_busy = 1'b1;
    end else if (busy) begin
      next_cnt = cnt - W'(1);
      if (cnt == W'(1)) begin
        next_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= '0;
      busy <= 1'b0;
    end else begin
      cnt <= next_cnt;
      busy <= next_busy;
    end
  end

endmodule // srp_delay

// [tb/srp_switch_model.sv]
// power switch and oscillator supply model for the sequencer bench
`timescale 1ns/1ns
module srp_switch_model (
  input wire logic i_press,
  input wire logic i_osc_power,
  output logic o_wake,
  output logic o_supply_on
);
  // momentary contact with a pull-down: a released switch reads low
  assign o_wake = i_press ? 1'b1 : 1'b0;
  // supply only follows the request; no settling margin is modelled
  assign o_supply_on = i_osc_power;
endmodule // srp_switch_model

// [tb/tb_suspend_resume_power_sequencer.sv]
// self-checking bench for the suspend/resume power sequencer
`timescale 1ns/1ns
module tb_suspend_resume_power_sequencer;
  // short step keeps the run small; the step-length checks derive from it, except the 1000-cycle quick resume
  localparam int unsigned STEP = 20;
  logic clk = 0, rst = 1, press = 0, tick = 0, we = 0, re = 0, hit;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [4:0] dir = 5'h00, pdat = 5'h00, pad = 5'h00, pout, poe, pval;
  logic wake, osc, tim, exec_ok, sup, lvl, supply;
  logic [31:0] tod;
  logic [7:0] mreg [0:255];
  logic [7:0] sctl [0:2] = '{8'h00, 8'h04, 8'h08};
  int n_errors = 0, checks = 0, seed = 96907, mtod = 0, n;
  always #50 clk = ~clk;
  srp_switch_model sw (.i_press(press), .i_osc_power(osc), .o_wake(wake), .o_supply_on(supply));
  srp_power_seq #(.SEQ_STEP_CYC(STEP)) dut (.I_MCLK(clk), .I_RST(rst),
    .I_WAKE_REQUEST_IN(wake), .I_TOD_TICK(tick), .I_CFG_WE(we), .I_CFG_RE(re),
    .I_CFG_ADDR(addr), .I_CFG_WDATA(wdata), .I_PPIN_DIR(dir), .I_PPIN_DATA(pdat),
    .I_PPIN_PAD(pad), .O_OSC_POWER_OUT(osc), .O_TIMING_EN(tim), .O_EXEC_PERMITTED(exec_ok),
    .O_SUPERVISOR_MODE_REQ(sup), .O_INPUT_LEVEL_SELECT(lvl), .O_CFG_RDATA(rdata),
    .O_TOD(tod), .O_PPIN_OUT(pout), .O_PPIN_OE(poe), .O_PPIN_VALUE(pval));
////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // unmapped offsets never reach the model, so they read back as zero
  // each access lets one edge pass first, so back-to-back strobes never glitch
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    we = 1; addr = a; wdata = d;
    @(negedge clk);
    we = 0;
    if (a inside {[8'h18:8'h1C], 8'h32}) mreg[a] = d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    re = 1; addr = a;
    @(negedge clk);
    re = 0;
    chk(rdata, mreg[a]);
  endtask
  task automatic wcmp(input logic [31:0] v);
    for (int i = 0; i < 4; i++) wr(8'h18 + 8'(i), v[8*i +: 8]);
  endtask
  task automatic tk();
    @(negedge clk);
    tick = 1;
    @(negedge clk);
    tick = 0;
    mtod++;
  endtask
  task automatic meas(input int sel, input logic v, output int k);
    logic s;
    for (k = 1; k <= 3000; k++) begin
      @(negedge clk);
      s = (sel == 0) ? osc : (sel == 1) ? tim : sup;
      if (s === v) return;
    end
    n_errors++;
    close_out();
  endtask
  task automatic sleep();
    wr(8'h1C, mreg[8'h1C] | 8'h01);
    meas(1, 0, n); chk(n, 1);
    chk(exec_ok, 0);
    meas(0, 0, n); chk(n, STEP);
    chk(supply, 0);
    mreg[8'h1C][0] = 1'b0;
    cyc(2);
    rd(8'h1C);
  endtask
////////////////////////////////////////
  initial begin
    for (int i = 0; i < 256; i++) mreg[i] = 8'h00;
    mreg[8'h32] = 8'h01;
    cyc(8);
    rst = 0;
    chk(lvl, 1);
    chk({osc, tim, exec_ok}, 3'h7);
    foreach (sctl[i]) rd(8'h18 + 8'(i));
    rd(8'h1B); rd(8'h1C); rd(8'h32); rd(8'h40);
    $display("test reset done");
    for (int i = 0; i < 4; i++) wr(8'h18 + 8'(i), 8'($random(seed)));
    wr(8'h40, 8'h55);
    for (int i = 0; i < 4; i++) rd(8'h18 + 8'(i));
    rd(8'h40);
    wr(8'h32, 8'h00); cyc(1); chk(lvl, 0);
    dir = 5'($random(seed)); pdat = 5'($random(seed)); pad = 5'($random(seed));
    cyc(2); chk({pout, poe, pval}, {pdat, dir, pad});
    $display("test registers done");
    wcmp(mtod + 1); tk(); tk(); cyc(5);
    chk({osc, tim}, 2'h3);
    chk(tod, mtod);
    $display("test active match done");
    sleep();
    tk(); tk(); cyc(1);
    chk(tod, mtod);
    rd(8'h32);
    press = 1;
    meas(0, 1, n); chk(n, 3);
    meas(1, 1, n); chk(n, STEP);
    chk(exec_ok, 1);
    press = 0;
    cyc(6); chk(tim, 1);
    $display("test pin wake done");
    wcmp(mtod + 2); sleep(); tk(); tk();
    meas(0, 1, n); chk(n, 1);
    meas(1, 1, n); chk(n, STEP);
    $display("test compare wake done");
    // comparator still equals the time count; park it ahead or suspend re-wakes at once
    wcmp(mtod + 100);
    wr(8'h1C, 8'h02); sleep(); press = 1;
    meas(0, 1, n); chk(n, 3);
    meas(1, 1, n); chk(n, 1000);
    press = 0; cyc(6);
    $display("test quick resume done");
    foreach (sctl[i]) begin
      wr(8'h1C, sctl[i]); cyc(2); press = 1; hit = 0;
      repeat (6) begin
        @(negedge clk);
        if (sup === 1'b1) hit = 1;
      end
      chk(hit, i > 0);
      chk(tim, 1);
      press = 0; hit = 0;
      repeat (6) begin
        @(negedge clk);
        if (sup === 1'b1) hit = 1;
      end
      chk(hit, i != 1);
      chk(tim, 1);
    end
    $display("test supervisor done");
    close_out();
  end
endmodule // tb_suspend_resume_power_sequencer
